// File: hw/lsw_pkg.sv
// Package for the loop status and heater current word area
package lsw_pkg;
  // Word indices within the exchanged area
  localparam logic [4:0] LSW_IDX_CTRL = 5'h02;
  localparam logic [4:0] LSW_IDX_L1_STATUS = 5'h08;
  localparam logic [4:0] LSW_IDX_L2_STATUS = 5'h09;
  localparam logic [4:0] LSW_IDX_L1_THRESH = 5'h0A;
  localparam logic [4:0] LSW_IDX_L2_THRESH = 5'h0B;
  localparam logic [4:0] LSW_IDX_SPARE_A = 5'h0C;
  localparam logic [4:0] LSW_IDX_L1_CURRENT = 5'h0D;
  localparam logic [4:0] LSW_IDX_L2_CURRENT = 5'h0E;
  localparam logic [4:0] LSW_IDX_L1_READBACK = 5'h0F;
  localparam logic [4:0] LSW_IDX_L2_READBACK = 5'h10;
  localparam logic [4:0] LSW_IDX_SPARE_B = 5'h11;
  localparam logic [4:0] LSW_IDX_SPARE_C = 5'h12;
  localparam logic [4:0] LSW_IDX_SPARE_D = 5'h13;
  // Bit positions
  localparam int LSW_BIT_SAVE_REQ = 14;
  localparam int LSW_BIT_SAVE_DONE = 15;
  localparam int LSW_BIT_SENSOR = 14;
  localparam int LSW_BIT_OVERFLOW = 13;
  localparam int LSW_BIT_FATAL = 12;
  localparam int LSW_BIT_STANDBY = 11;
  localparam int LSW_BIT_TUNED = 10;
  localparam int LSW_BIT_CONFIG = 9;
  localparam int LSW_BIT_HALT = 8;
  localparam int LSW_BIT_OUTPUT = 4;
  localparam int LSW_BIT_AUTOTUNE = 3;
  localparam int LSW_BIT_HEATER = 2;
  localparam int LSW_BIT_ALARM1 = 1;
  localparam int LSW_BIT_ALARM2 = 0;
  // Current values in tenths of an ampere
  localparam logic [15:0] LSW_CT_LIMIT = 16'h0226;
  localparam logic [15:0] LSW_THR_OFF = 16'h0000;
  localparam logic [15:0] LSW_THR_WIRING = 16'h01F4;
  localparam logic [15:0] LSW_OVERFLOW_CODE = 16'hCCCC;
  localparam logic [15:0] LSW_BCD_MAX = 16'h270F;
  // Reset values
  localparam logic [15:0] LSW_RST_WORD = 16'h0000;
  localparam logic [15:0] LSW_RST_L2_STATUS = 16'h0800;

  typedef enum logic [0:0] {
    LSW_SAVE_IDLE,
    LSW_SAVE_COPY
  } lsw_save_t;

  // Live inputs of one control loop
  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] al1_lo;
    logic [15:0] al1_hi;
    logic [15:0] al2_lo;
    logic [15:0] al2_hi;
    logic [15:0] heater_current;
    logic sensor_absent;
    logic sensor_broken;
    logic temp_out_of_range;
    logic cjc_fail;
    logic ctrl_out;
    logic autotuning;
    logic pid_updated;
    logic settings_invalid;
    logic regulating;
  } lsw_loop_in_t;

  // One word access of the host during I/O refresh
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [15:0] wdata;
  } lsw_host_req_t;

  typedef struct packed {
    logic standby;
    logic save_done;
    logic save_bit;
    lsw_save_t save_state;
    logic copy_req;
    logic tuned;
    logic [1:0][15:0] thr_pend;
    logic [1:0][15:0] thr_eff;
    logic [15:0] snap_status1;
    logic [15:0] snap_status2;
    logic [1:0][15:0] snap_current;
    logic [1:0][15:0] snap_readback;
    logic [15:0] rdata;
    logic rvalid;
    logic [1:0] burnout;
  } lsw_state_t;
endpackage

// File: hw/lsw_word_area.sv
// Loop status, burnout threshold and heater current word area
`timescale 1ns/1ps
module lsw_word_area (
  input wire logic ref_clk, // 40 MHz clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic refresh_start, // Pulse: host I/O refresh begins
  input wire logic refresh_end, // Pulse: host I/O refresh ends
  input wire lsw_pkg::lsw_host_req_t host_req, // Host word access
  input wire logic bcd_mode, // Words carry BCD when high
  input wire lsw_pkg::lsw_loop_in_t [1:0] loop_in, // Live loop inputs
  input wire logic host_wdt_error, // Host watchdog error level
  input wire logic pid_delivered, // Pulse: host sent tuned constants
  input wire logic copy_done, // Pulse: RAM to EEPROM copy finished
  output logic [15:0] io_rdata, // Read word
  output logic io_rvalid, // Read word valid pulse
  output logic copy_req, // Pulse: start RAM to EEPROM copy
  output logic [1:0] burnout_out // Heater burnout output per loop
);
  lsw_pkg::lsw_state_t st;
  lsw_pkg::lsw_state_t next_st;
  logic [1:0] al1_in;
  logic [1:0] al2_in;
  logic [1:0] overflow;
  logic [1:0] heater_fail;
  logic [1:0] thr_test;
  logic [1:0][15:0] cur_word;
  logic save_rise;
  logic config_fault;
  logic [15:0] live_status1;
  logic [15:0] live_status2;

  function automatic logic [15:0] bcd_to_bin(input logic [15:0] bcd);
    logic [15:0] acc;
    acc = 16'h0000;
    for (int i = 3; i >= 0; i--) begin
      acc = 16'((acc * 16'h000A) + {12'h000, bcd[i*4 +: 4]});
    end
    return acc;
  endfunction

  function automatic logic [15:0] bin_to_bcd(input logic [15:0] bin);
    logic [15:0] val;
    logic [31:0] sh;
    val = (bin > lsw_pkg::LSW_BCD_MAX) ? lsw_pkg::LSW_BCD_MAX : bin;
    sh = {16'h0000, val};
    for (int i = 0; i < 16; i++) begin
      for (int d = 0; d < 4; d++) begin
        if (sh[16 + d*4 +: 4] > 4'h4) begin
          sh[16 + d*4 +: 4] = 4'(sh[16 + d*4 +: 4] + 4'h3);
        end
      end
      sh = {sh[30:0], 1'b0};
    end
    return sh[31:16];
  endfunction

  function automatic logic bcd_ok(input logic [15:0] bcd);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (bcd[i*4 +: 4] > 4'h9) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // Threshold word in the host's format, as a binary count of tenths
  function automatic logic [15:0] to_bin(input logic [15:0] w, input logic bcd);
    return bcd ? bcd_to_bin(w) : w;
  endfunction

  always_comb begin
    config_fault = 1'b0;
    for (int l = 0; l < 2; l++) begin
      al1_in[l] = (loop_in[l].temp >= loop_in[l].al1_lo) &&
                  (loop_in[l].temp <= loop_in[l].al1_hi);
      al2_in[l] = (loop_in[l].temp >= loop_in[l].al2_lo) &&
                  (loop_in[l].temp <= loop_in[l].al2_hi);
      overflow[l] = loop_in[l].heater_current > lsw_pkg::LSW_CT_LIMIT;
      thr_test[l] = to_bin(st.thr_eff[l], bcd_mode) == lsw_pkg::LSW_THR_WIRING;
      heater_fail[l] = thr_test[l] ||
        ((to_bin(st.thr_eff[l], bcd_mode) != lsw_pkg::LSW_THR_OFF) &&
         (loop_in[l].heater_current >= to_bin(st.thr_eff[l], bcd_mode)));
      if (overflow[l]) begin
        cur_word[l] = lsw_pkg::LSW_OVERFLOW_CODE;
      end else if (bcd_mode) begin
        cur_word[l] = bin_to_bcd(loop_in[l].heater_current);
      end else begin
        cur_word[l] = loop_in[l].heater_current;
      end
      if (loop_in[l].settings_invalid || (bcd_mode && !bcd_ok(st.thr_eff[l]))) begin
        config_fault = 1'b1;
      end
    end
  end

  assign save_rise = host_req.wr && (host_req.addr == lsw_pkg::LSW_IDX_CTRL) &&
                     host_req.wdata[lsw_pkg::LSW_BIT_SAVE_REQ] && !st.save_bit;

  always_comb begin
    live_status1 = lsw_pkg::LSW_RST_WORD;
    live_status1[lsw_pkg::LSW_BIT_ALARM1] = al1_in[0];
    live_status1[lsw_pkg::LSW_BIT_ALARM2] = al2_in[0];
    live_status2 = lsw_pkg::LSW_RST_WORD;
    live_status2[lsw_pkg::LSW_BIT_SAVE_DONE] = st.save_done;
    live_status2[lsw_pkg::LSW_BIT_SENSOR] = loop_in[1].sensor_absent ||
      loop_in[1].sensor_broken || loop_in[1].temp_out_of_range;
    live_status2[lsw_pkg::LSW_BIT_OVERFLOW] = overflow[1];
    live_status2[lsw_pkg::LSW_BIT_FATAL] = loop_in[1].cjc_fail || host_wdt_error;
    live_status2[lsw_pkg::LSW_BIT_STANDBY] = st.standby;
    live_status2[lsw_pkg::LSW_BIT_TUNED] = st.tuned;
    live_status2[lsw_pkg::LSW_BIT_CONFIG] = config_fault;
    live_status2[lsw_pkg::LSW_BIT_HALT] = !loop_in[1].regulating;
    live_status2[lsw_pkg::LSW_BIT_OUTPUT] = loop_in[1].ctrl_out;
    live_status2[lsw_pkg::LSW_BIT_AUTOTUNE] = loop_in[1].autotuning;
    live_status2[lsw_pkg::LSW_BIT_HEATER] = heater_fail[1];
    live_status2[lsw_pkg::LSW_BIT_ALARM1] = al1_in[1];
    live_status2[lsw_pkg::LSW_BIT_ALARM2] = al2_in[1];
  end

  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    next_st.copy_req = 1'b0;
    next_st.burnout = heater_fail;
    // Tuned constants: a new result wins over a delivery in the same cycle
    if (pid_delivered) begin
      next_st.tuned = 1'b0;
    end
    if (loop_in[1].pid_updated) begin
      next_st.tuned = 1'b1;
    end
    case (st.save_state)
      lsw_pkg::LSW_SAVE_IDLE: begin
        if (save_rise) begin
          next_st.save_done = 1'b0;
          next_st.copy_req = 1'b1;
          next_st.save_state = lsw_pkg::LSW_SAVE_COPY;
        end
      end
      lsw_pkg::LSW_SAVE_COPY: begin
        if (copy_done) begin
          next_st.save_done = 1'b1;
          next_st.save_state = lsw_pkg::LSW_SAVE_IDLE;
        end
      end
      default: begin
        next_st.save_state = lsw_pkg::LSW_SAVE_IDLE;
      end
    endcase
    if (host_req.wr) begin
      case (host_req.addr)
        lsw_pkg::LSW_IDX_CTRL: begin
          next_st.save_bit = host_req.wdata[lsw_pkg::LSW_BIT_SAVE_REQ];
        end
        lsw_pkg::LSW_IDX_L1_THRESH: begin
          next_st.thr_pend[0] = host_req.wdata;
        end
        lsw_pkg::LSW_IDX_L2_THRESH: begin
          next_st.thr_pend[1] = host_req.wdata;
        end
        default: begin
        end
      endcase
    end
    // Thresholds written during a transfer take effect when it ends
    if (refresh_end) begin
      next_st.thr_eff = next_st.thr_pend;
    end
    // Monitor words are captured once per refresh and held through it
    if (refresh_start) begin
      next_st.standby = 1'b0;
      next_st.snap_status1 = live_status1;
      next_st.snap_status2 = live_status2;
      next_st.snap_status2[lsw_pkg::LSW_BIT_STANDBY] = 1'b0;
      next_st.snap_current = cur_word;
      next_st.snap_readback = st.thr_eff;
    end
    if (host_req.rd) begin
      next_st.rvalid = 1'b1;
      case (host_req.addr)
        lsw_pkg::LSW_IDX_L1_STATUS: next_st.rdata = st.snap_status1;
        lsw_pkg::LSW_IDX_L2_STATUS: next_st.rdata = st.snap_status2;
        lsw_pkg::LSW_IDX_L1_THRESH: next_st.rdata = st.thr_pend[0];
        lsw_pkg::LSW_IDX_L2_THRESH: next_st.rdata = st.thr_pend[1];
        lsw_pkg::LSW_IDX_L1_CURRENT: next_st.rdata = st.snap_current[0];
        lsw_pkg::LSW_IDX_L2_CURRENT: next_st.rdata = st.snap_current[1];
        lsw_pkg::LSW_IDX_L1_READBACK: next_st.rdata = st.snap_readback[0];
        lsw_pkg::LSW_IDX_L2_READBACK: next_st.rdata = st.snap_readback[1];
        default: next_st.rdata = lsw_pkg::LSW_RST_WORD;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '0;
      st.standby <= 1'b1;
      st.save_done <= 1'b0;
      st.save_state <= lsw_pkg::LSW_SAVE_IDLE;
      st.snap_status2 <= lsw_pkg::LSW_RST_L2_STATUS;
    end else begin
      st <= next_st;
    end
  end

  assign io_rdata = st.rdata;
  assign io_rvalid = st.rvalid;
  assign copy_req = st.copy_req;
  assign burnout_out = st.burnout;

  property p_alarm_snap;
    @(posedge ref_clk) disable iff (rst)
    refresh_start |=> (st.snap_status2[1:0] == $past({al1_in[1], al2_in[1]})) &&
      (st.snap_status1[1:0] == $past({al1_in[0], al2_in[0]}));
  endproperty
  a_alarm_snap: assert property (p_alarm_snap) else $error("alarm bits not captured");

  property p_save_start;
    @(posedge ref_clk) disable iff (rst)
    (save_rise && st.save_state == lsw_pkg::LSW_SAVE_IDLE) |=>
      !st.save_done && copy_req ##1 !copy_req;
  endproperty
  a_save_start: assert property (p_save_start) else $error("save start wrong");

  property p_save_finish;
    @(posedge ref_clk) disable iff (rst)
    (st.save_state == lsw_pkg::LSW_SAVE_COPY && copy_done) |=> st.save_done;
  endproperty
  a_save_finish: assert property (p_save_finish) else $error("save done not set");

  property p_sensor;
    @(posedge ref_clk) disable iff (rst)
    (refresh_start && (loop_in[1].sensor_broken || loop_in[1].sensor_absent)) |=>
      st.snap_status2[lsw_pkg::LSW_BIT_SENSOR];
  endproperty
  a_sensor: assert property (p_sensor) else $error("sensor fault missed");

  property p_overflow;
    @(posedge ref_clk) disable iff (rst)
    (refresh_start && loop_in[1].heater_current > lsw_pkg::LSW_CT_LIMIT) |=>
      st.snap_status2[lsw_pkg::LSW_BIT_OVERFLOW] &&
      st.snap_current[1] == lsw_pkg::LSW_OVERFLOW_CODE;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not reported");

  property p_fatal;
    @(posedge ref_clk) disable iff (rst)
    (refresh_start && host_wdt_error) |=> st.snap_status2[lsw_pkg::LSW_BIT_FATAL];
  endproperty
  a_fatal: assert property (p_fatal) else $error("fatal flag missed");

  property p_standby;
    @(posedge ref_clk) disable iff (rst)
    (st.standby && !refresh_start) |=> st.standby;
  endproperty
  a_standby: assert property (p_standby) else $error("standby left early");

  property p_tuned;
    @(posedge ref_clk) disable iff (rst)
    loop_in[1].pid_updated |=> st.tuned;
  endproperty
  a_tuned: assert property (p_tuned) else $error("tuned flag lost");

  property p_spare;
    @(posedge ref_clk) disable iff (rst)
    (host_req.rd && (host_req.addr == lsw_pkg::LSW_IDX_SPARE_A ||
      host_req.addr == lsw_pkg::LSW_IDX_SPARE_D)) |=> io_rvalid && io_rdata == 16'h0000;
  endproperty
  a_spare: assert property (p_spare) else $error("spare word not zero");

  property p_wiring;
    @(posedge ref_clk) disable iff (rst)
    (to_bin(st.thr_eff[0], bcd_mode) == lsw_pkg::LSW_THR_WIRING) |=> burnout_out[0];
  endproperty
  a_wiring: assert property (p_wiring) else $error("wiring test output off");

  property p_disabled;
    @(posedge ref_clk) disable iff (rst)
    (st.thr_eff[1] == lsw_pkg::LSW_THR_OFF) |=> !burnout_out[1];
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled burnout fired");

  property p_stable;
    @(posedge ref_clk) disable iff (rst)
    !refresh_start |=> $stable(st.snap_status2) && $stable(st.snap_current);
  endproperty
  a_stable: assert property (p_stable) else $error("monitor word moved");

  property p_save_hold;
    @(posedge ref_clk) disable iff (rst)
    (st.save_state == lsw_pkg::LSW_SAVE_COPY && !copy_done) |=> !st.save_done;
  endproperty
  a_save_hold: assert property (p_save_hold) else $error("save done set early");

  property p_halt;
    @(posedge ref_clk) disable iff (rst)
    refresh_start |=>
      st.snap_status2[lsw_pkg::LSW_BIT_HALT] == $past(!loop_in[1].regulating);
  endproperty
  a_halt: assert property (p_halt) else $error("halt flag wrong");

  property p_output;
    @(posedge ref_clk) disable iff (rst)
    refresh_start |=>
      st.snap_status2[lsw_pkg::LSW_BIT_OUTPUT] == $past(loop_in[1].ctrl_out);
  endproperty
  a_output: assert property (p_output) else $error("output flag wrong");

  property p_autotune;
    @(posedge ref_clk) disable iff (rst)
    refresh_start |=>
      st.snap_status2[lsw_pkg::LSW_BIT_AUTOTUNE] == $past(loop_in[1].autotuning);
  endproperty
  a_autotune: assert property (p_autotune) else $error("autotune flag wrong");

  property p_config;
    @(posedge ref_clk) disable iff (rst)
    (refresh_start && (loop_in[0].settings_invalid || loop_in[1].settings_invalid)) |=>
      st.snap_status2[lsw_pkg::LSW_BIT_CONFIG];
  endproperty
  a_config: assert property (p_config) else $error("config fault missed");

  property p_current;
    @(posedge ref_clk) disable iff (rst)
    (refresh_start && !bcd_mode && loop_in[0].heater_current <= lsw_pkg::LSW_CT_LIMIT) |=>
      st.snap_current[0] == $past(loop_in[0].heater_current);
  endproperty
  a_current: assert property (p_current) else $error("current word wrong");

  property p_readback;
    @(posedge ref_clk) disable iff (rst)
    refresh_start |=> st.snap_readback == $past(st.thr_eff);
  endproperty
  a_readback: assert property (p_readback) else $error("readback word wrong");

  property p_heater;
    @(posedge ref_clk) disable iff (rst)
    (!bcd_mode && st.thr_eff[1] != lsw_pkg::LSW_THR_OFF &&
      loop_in[1].heater_current >= st.thr_eff[1]) |=> burnout_out[1];
  endproperty
  a_heater: assert property (p_heater) else $error("heater failure missed");

  property p_tuned_clear;
    @(posedge ref_clk) disable iff (rst)
    (pid_delivered && !loop_in[1].pid_updated) |=> !st.tuned;
  endproperty
  a_tuned_clear: assert property (p_tuned_clear) else $error("tuned flag kept");

  property p_rvalid;
    @(posedge ref_clk) disable iff (rst)
    io_rvalid == $past(host_req.rd);
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read valid wrong");

  property p_standby_clear;
    @(posedge ref_clk) disable iff (rst)
    refresh_start |=> !st.standby;
  endproperty
  a_standby_clear: assert property (p_standby_clear) else $error("standby kept");
endmodule

// File: tb/lsw_host_model.sv
// Host controller model: refresh framing, word accesses and copy completion
`timescale 1ns/1ps
module lsw_host_model (
  input wire logic ref_clk, // 40 MHz clock
  input wire logic [15:0] io_rdata, // Read word
  input wire logic io_rvalid, // Read word valid
  input wire logic copy_req, // Copy start pulse
  output logic refresh_start, // Refresh begins
  output logic refresh_end, // Refresh ends
  output lsw_pkg::lsw_host_req_t host_req, // Word access
  output logic copy_done // Copy finished pulse
);
  int copy_wait = 1;
  int copies = 0;

  initial begin
    refresh_start = 1'b0;
    refresh_end = 1'b0;
    host_req = '0;
    copy_done = 1'b0;
  end

  // One refresh boundary pulse: start when last is low, end when high
  task automatic frame(input logic last);
    @(negedge ref_clk);
    if (last) refresh_end = 1'b1;
    else refresh_start = 1'b1;
    @(negedge ref_clk);
    refresh_start = 1'b0;
    refresh_end = 1'b0;
  endtask

  // Thresholds and the save bit are written here; released data is inverted
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    host_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge ref_clk);
    host_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic v);
    @(negedge ref_clk);
    host_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
    @(negedge ref_clk);
    // The answer stands for one cycle only, so take it before releasing
    d = io_rdata;
    v = io_rvalid;
    host_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 16'hFFFF};
  endtask

  // Copy completes after a settable number of cycles, prompt or slow
  always @(negedge ref_clk) begin
    if (copy_req === 1'b1) begin
      copies++;
      repeat (copy_wait) @(negedge ref_clk);
      copy_done = 1'b1;
      @(negedge ref_clk);
      copy_done = 1'b0;
    end
  end
endmodule

// File: tb/lsw_word_area_tb.sv
// Self-checking bench for the loop status and heater current word area
`timescale 1ns/1ps
module lsw_word_area_tb;
  logic ref_clk, rst, refresh_start, refresh_end, bcd_mode, host_wdt_error, pid_delivered;
  logic copy_done, io_rvalid, copy_req;
  logic [15:0] io_rdata;
  logic [1:0] burnout_out;
  lsw_pkg::lsw_host_req_t host_req;
  lsw_pkg::lsw_loop_in_t [1:0] loop_in;
  int fails = 0;
  int checked = 0;
  localparam int FLAG_BIT [9] = '{14, 14, 14, 12, 12, 4, 3, 9, 8};
  localparam logic [4:0] SPARE [5] = '{5'h0C, 5'h11, 5'h12, 5'h13, 5'h1F};

  lsw_word_area dut (.ref_clk, .rst, .refresh_start, .refresh_end, .host_req, .bcd_mode,
    .loop_in, .host_wdt_error, .pid_delivered, .copy_done, .io_rdata, .io_rvalid,
    .copy_req, .burnout_out);
  lsw_host_model host (.ref_clk, .io_rdata, .io_rvalid, .copy_req, .refresh_start,
    .refresh_end, .host_req, .copy_done);

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic v;
    host.rd(a, d, v);
    chk("read valid", {15'h0000, v}, 16'h0001);
    chk($sformatf("word %h", a), d, exp);
  endtask

  // Reads one word inside a complete refresh
  task automatic snap(input logic [4:0] a, input logic [15:0] exp);
    host.frame(1'b0);
    rd_chk(a, exp);
    host.frame(1'b1);
  endtask

  function automatic lsw_pkg::lsw_loop_in_t base_loop();
    lsw_pkg::lsw_loop_in_t l;
    l = '0;
    l.temp = 16'h0064;
    l.al1_lo = 16'h0032;
    l.al1_hi = 16'h0096;
    l.al2_lo = 16'h00C8;
    l.al2_hi = 16'h012C;
    l.heater_current = 16'h0064;
    l.regulating = 1'b1;
    return l;
  endfunction

  task automatic t_standby();
    rd_chk(lsw_pkg::LSW_IDX_L2_STATUS, 16'h0800);
    host.frame(1'b0);
    host.wr(5'h0C, 16'hA5A5);
    rd_chk(lsw_pkg::LSW_IDX_L2_STATUS, 16'h0002);
    rd_chk(lsw_pkg::LSW_IDX_L1_STATUS, 16'h0002);
    foreach (SPARE[k]) rd_chk(SPARE[k], 16'h0000);
    host.frame(1'b1);
  endtask

  // Each cause is withdrawn right after the snapshot edge
  task automatic t_flags();
    for (int i = 0; i < 9; i++) begin
      case (i)
        0: loop_in[1].sensor_absent = 1'b1;
        1: loop_in[1].sensor_broken = 1'b1;
        2: loop_in[1].temp_out_of_range = 1'b1;
        3: loop_in[1].cjc_fail = 1'b1;
        4: host_wdt_error = 1'b1;
        5: loop_in[1].ctrl_out = 1'b1;
        6: loop_in[1].autotuning = 1'b1;
        7: loop_in[1].settings_invalid = 1'b1;
        default: loop_in[1].regulating = 1'b0;
      endcase
      host.frame(1'b0);
      loop_in[1] = base_loop();
      host_wdt_error = 1'b0;
      rd_chk(lsw_pkg::LSW_IDX_L2_STATUS, 16'h0002 | (16'h0001 << FLAG_BIT[i]));
      host.frame(1'b1);
    end
  endtask

  task automatic t_alarm();
    loop_in[0].temp = 16'h00D0;
    loop_in[0].al1_hi = 16'h0100;
    snap(lsw_pkg::LSW_IDX_L1_STATUS, 16'h0003);
    loop_in[0].temp = 16'h0200;
    snap(lsw_pkg::LSW_IDX_L1_STATUS, 16'h0000);
    loop_in[0] = base_loop();
  endtask

  // Loop 1 flags stay out of word 9 except its settings fault, which sets the config bit; both loops get their own alarm ranges
  task automatic t_cross();
    // Loop 1: every flag set, not regulating, alarm 2 range only
    loop_in[0] = {16'h0064, 16'h0070, 16'h0096, 16'h0050, 16'h0070, 16'h0064, 9'h1FE};
    // Loop 2: regulating, alarm 2 range only
    loop_in[1] = {16'h00FA, 16'h0000, 16'h0010, 16'h00F0, 16'h0100, 16'h0064, 9'h001};
    host.frame(1'b0);
    rd_chk(lsw_pkg::LSW_IDX_L1_STATUS, 16'h0001);
    rd_chk(lsw_pkg::LSW_IDX_L2_STATUS, 16'h0201);
    host.frame(1'b1);
    loop_in = {base_loop(), base_loop()};
  endtask

  // Loop 1 threshold in BCD: wiring test, readback and a bad digit
  task automatic t_loop1_thr();
    bcd_mode = 1'b1;
    host.frame(1'b0);
    host.wr(lsw_pkg::LSW_IDX_L1_THRESH, 16'h0500);
    host.frame(1'b1);
    repeat (2) @(negedge ref_clk);
    chk("burnout output", {14'h0000, burnout_out}, 16'h0001);
    host.frame(1'b0);
    rd_chk(lsw_pkg::LSW_IDX_L1_READBACK, 16'h0500);
    host.wr(lsw_pkg::LSW_IDX_L1_THRESH, 16'h00AB);
    host.frame(1'b1);
    snap(lsw_pkg::LSW_IDX_L2_STATUS, 16'h0202);
    host.wr(lsw_pkg::LSW_IDX_L1_THRESH, 16'h0000);
    snap(lsw_pkg::LSW_IDX_L1_READBACK, 16'h00AB);
    bcd_mode = 1'b0;
  endtask

  task automatic t_current();
    loop_in[1].heater_current = 16'h0226;
    snap(lsw_pkg::LSW_IDX_L2_CURRENT, 16'h0226);
    loop_in[1].heater_current = 16'h0227;
    host.frame(1'b0);
    rd_chk(lsw_pkg::LSW_IDX_L2_CURRENT, 16'hCCCC);
    rd_chk(lsw_pkg::LSW_IDX_L2_STATUS, 16'h2002);
    host.frame(1'b1);
    bcd_mode = 1'b1;
    loop_in[0].heater_current = 16'h0123;
    snap(lsw_pkg::LSW_IDX_L1_CURRENT, 16'h0291);
    bcd_mode = 1'b0;
    loop_in = {base_loop(), base_loop()};
  endtask

  task automatic bo_row(input logic [15:0] thr, input logic [15:0] cur, input logic bo);
    loop_in[1].heater_current = cur;
    host.frame(1'b0);
    host.wr(lsw_pkg::LSW_IDX_L2_THRESH, thr);
    rd_chk(lsw_pkg::LSW_IDX_L2_THRESH, thr);
    host.frame(1'b1);
    repeat (2) @(negedge ref_clk);
    chk("burnout output", {14'h0000, burnout_out}, {14'h0000, bo, 1'b0});
    host.frame(1'b0);
    rd_chk(lsw_pkg::LSW_IDX_L2_READBACK, thr);
    if (thr != 16'h01F4) rd_chk(lsw_pkg::LSW_IDX_L2_STATUS, {13'h0000, bo, 2'b10});
    host.frame(1'b1);
  endtask

  task automatic t_burnout();
    bo_row(16'h0064, 16'h0064, 1'b1);
    bo_row(16'h0065, 16'h0064, 1'b0);
    bo_row(16'h0000, 16'h0000, 1'b0);
    bo_row(16'h01F4, 16'h0000, 1'b1);
    bo_row(16'h0000, 16'h0064, 1'b0);
  endtask

  task automatic t_save();
    host.wr(lsw_pkg::LSW_IDX_CTRL, 16'h4000);
    repeat (4) @(negedge ref_clk);
    snap(lsw_pkg::LSW_IDX_L2_STATUS, 16'h8002);
    host.wr(lsw_pkg::LSW_IDX_CTRL, 16'h4000);
    host.wr(lsw_pkg::LSW_IDX_CTRL, 16'h0000);
    host.copy_wait = 20;
    host.wr(lsw_pkg::LSW_IDX_CTRL, 16'h4000);
    snap(lsw_pkg::LSW_IDX_L2_STATUS, 16'h0002);
    repeat (25) @(negedge ref_clk);
    snap(lsw_pkg::LSW_IDX_L2_STATUS, 16'h8002);
    chk("copy count", 16'(host.copies), 16'h0002);
  endtask

  task automatic t_tuned();
    loop_in[1].pid_updated = 1'b1;
    @(negedge ref_clk);
    loop_in[1].pid_updated = 1'b0;
    snap(lsw_pkg::LSW_IDX_L2_STATUS, 16'h8402);
    pid_delivered = 1'b1;
    @(negedge ref_clk);
    pid_delivered = 1'b0;
    snap(lsw_pkg::LSW_IDX_L2_STATUS, 16'h8002);
  endtask

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    bcd_mode = 1'b0;
    host_wdt_error = 1'b0;
    pid_delivered = 1'b0;
    loop_in = {base_loop(), base_loop()};
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    t_standby();
    t_flags();
    t_alarm();
    t_cross();
    t_current();
    t_burnout();
    t_loop1_thr();
    t_save();
    t_tuned();
    test_done();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    fails++;
    test_done();
  end
endmodule
